// ===== verilog/pdc_pkg.sv
// shared constants and carrier types for the pll divider setting calculator
package pdc_pkg;
    localparam int N_W         = 12;
    localparam int M_W         = 9;
    localparam int R_W         = 9;
    localparam int Q_W         = 6;
    localparam int P_W         = 3;
    localparam int PDIV_W      = 7;
    localparam int NS_W        = 16;
    localparam int REM_W       = 10;
    localparam int CNT_W       = 5;
    localparam int CFG_W       = 30;
    localparam int P_BASE      = 4;
    localparam int P_MAX       = 4;
    localparam int Q_MIN       = 16;
    localparam int Q_MAX       = 63;
    localparam int R_MAX       = 511;
    localparam int VCO_MIN_KHZ = 80000;
    localparam int VCO_MAX_KHZ = 200000;
    localparam int REF_KHZ_DEF = 27000;
    localparam int DIV_STEPS   = 16;
    localparam int LAT_CYC     = 18;
    localparam logic [CNT_W-1:0] CNT_LAST = 5'h0f;
    localparam logic [CFG_W-1:0] CFG_RST  = 30'h00000000;

    typedef struct packed {
        logic [N_W-1:0]    n;
        logic [M_W-1:0]    m;
        logic [PDIV_W-1:0] pdiv;
    } pdc_req_t;

    typedef struct packed {
        logic [N_W-1:0] n;
        logic [R_W-1:0] r;
        logic [Q_W-1:0] q;
        logic [P_W-1:0] p;
    } pdc_cfg_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_DIV  = 3'b010,
        ST_FIN  = 3'b100
    } pdc_state_t;
endpackage

// ===== verilog/pdc_calc.sv
// pll divider setting calculator: turns n, m, pdiv into stored p, q, r, n
`timescale 1ns/1ps

module pdc_calc
    import pdc_pkg::*;
#(
    parameter int REF_KHZ = REF_KHZ_DEF
) (
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic              req_valid,
    input  wire pdc_req_t          req,
    output logic                   busy,
    output logic                   done,
    output logic                   invalid,
    output pdc_cfg_t               cfg,
    output logic [PDIV_W-1:0]      pdiv,
    output logic                   standby
);

    // the reference must fit the 32-bit band products below
    if (REF_KHZ < 1 || REF_KHZ > 131071) begin : g_bad_ref
        $error("REF_KHZ out of range");
    end

    localparam logic [31:0] REF_U = 32'(REF_KHZ);

    pdc_state_t           state_reg,  state_next;
    pdc_req_t             req_reg,    req_next;
    logic [P_W-1:0]       p_reg,      p_next;
    logic [NS_W-1:0]      dvd_reg,    dvd_next;
    logic [NS_W-1:0]      quo_reg,    quo_next;
    logic [REM_W-1:0]     rem_reg,    rem_next;
    logic [CNT_W-1:0]     cnt_reg,    cnt_next;
    logic                 in_ok_reg,  in_ok_next;
    logic                 busy_reg,   busy_next;
    logic                 done_reg,   done_next;
    logic                 inv_reg,    inv_next;
    pdc_cfg_t             cfg_reg,    cfg_next;
    logic [PDIV_W-1:0]    pdiv_reg,   pdiv_next;
    logic                 stby_reg,   stby_next;

    logic                 accept;
    logic [P_W-1:0]       p_calc;
    logic [31:0]          f_num;
    logic [31:0]          f_lo;
    logic [31:0]          f_hi;
    logic [REM_W-1:0]     rem_sh;
    logic                 out_ok;

    assign accept = req_valid && (state_reg == ST_IDLE);

    // floor log2 of n/m found as the largest k with m<<k <= n
    always_comb begin
        logic [3:0] k;
        k = 4'h0;
        for (int i = 1; i < N_W; i++) begin
            if (({23'h0, req.m} << i) <= {20'h0, req.n}) begin
                k = 4'(i);
            end
        end
        if (k >= 4'(P_BASE)) begin
            p_calc = 3'h0;
        end else begin
            p_calc = 3'(P_BASE - int'(k));
        end
    end

    // vco band test done by multiplying, avoiding a second divider
    assign f_num = REF_U * {20'h0, req.n};
    assign f_lo  = 32'(VCO_MIN_KHZ) * {23'h0, req.m};
    assign f_hi  = 32'(VCO_MAX_KHZ) * {23'h0, req.m};

    // one restoring step per cycle keeps the divider small
    assign rem_sh = {rem_reg[REM_W-2:0], dvd_reg[NS_W-1]};

    // derived-value range check on the finished quotient
    assign out_ok = in_ok_reg
                 && (quo_reg >= 16'(Q_MIN))
                 && (quo_reg <= 16'(Q_MAX))
                 && (rem_reg <= 10'(R_MAX))
                 && (p_reg <= 3'(P_MAX));

    // next-state and datapath
    always_comb begin
        state_next = state_reg;
        req_next   = req_reg;
        p_next     = p_reg;
        dvd_next   = dvd_reg;
        quo_next   = quo_reg;
        rem_next   = rem_reg;
        cnt_next   = cnt_reg;
        in_ok_next = in_ok_reg;
        inv_next   = inv_reg;
        cfg_next   = cfg_reg;
        pdiv_next  = pdiv_reg;
        stby_next  = stby_reg;
        done_next  = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (accept) begin
                    req_next   = req;
                    p_next     = p_calc;
                    dvd_next   = NS_W'({4'h0, req.n} << p_calc);
                    quo_next   = '0;
                    rem_next   = '0;
                    cnt_next   = '0;
                    in_ok_next = (req.n != '0) && (req.m != '0)
                              && (req.n >= 12'(req.m))
                              && (f_num >= f_lo) && (f_num <= f_hi);
                    state_next = ST_DIV;
                end
            end
            ST_DIV: begin
                if (rem_sh >= {1'b0, req_reg.m}) begin
                    rem_next = rem_sh - {1'b0, req_reg.m};
                    quo_next = {quo_reg[NS_W-2:0], 1'b1};
                end else begin
                    rem_next = rem_sh;
                    quo_next = {quo_reg[NS_W-2:0], 1'b0};
                end
                dvd_next = {dvd_reg[NS_W-2:0], 1'b0};
                cnt_next = cnt_reg + 5'h01;
                if (cnt_reg == CNT_LAST) begin
                    state_next = ST_FIN;
                end
            end
            ST_FIN: begin
                done_next  = 1'b1;
                inv_next   = !out_ok;
                if (out_ok) begin
                    cfg_next.n = req_reg.n;
                    cfg_next.r = rem_reg[R_W-1:0];
                    cfg_next.q = quo_reg[Q_W-1:0];
                    cfg_next.p = p_reg;
                    pdiv_next  = req_reg.pdiv;
                    stby_next  = (req_reg.pdiv == '0);
                end
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        busy_next = (state_next != ST_IDLE);
    end

    // registers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            req_reg   <= '0;
            p_reg     <= '0;
            dvd_reg   <= '0;
            quo_reg   <= '0;
            rem_reg   <= '0;
            cnt_reg   <= '0;
            in_ok_reg <= 1'b0;
            busy_reg  <= 1'b0;
            done_reg  <= 1'b0;
            inv_reg   <= 1'b0;
            cfg_reg   <= CFG_RST;
            pdiv_reg  <= '0;
            stby_reg  <= 1'b1;   // no divider runs before a setting
        end else begin
            state_reg <= state_next;
            req_reg   <= req_next;
            p_reg     <= p_next;
            dvd_reg   <= dvd_next;
            quo_reg   <= quo_next;
            rem_reg   <= rem_next;
            cnt_reg   <= cnt_next;
            in_ok_reg <= in_ok_next;
            busy_reg  <= busy_next;
            done_reg  <= done_next;
            inv_reg   <= inv_next;
            cfg_reg   <= cfg_next;
            pdiv_reg  <= pdiv_next;
            stby_reg  <= stby_next;
        end
    end

    assign busy    = busy_reg;
    assign done    = done_reg;
    assign invalid = inv_reg;
    assign cfg     = cfg_reg;
    assign pdiv    = pdiv_reg;
    assign standby = stby_reg;

    // checks on latency, the busy span and the finished result
    a_fixed_latency: assert property (@(posedge mclk) disable iff (!rst_n)
        (req_valid && !busy_reg) |-> ##18 done_reg)
        else $error("done not seen 18 cycles after accept");

    a_invalid_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        (done_reg && inv_reg) |-> (cfg_reg == $past(cfg_reg)
                                   && pdiv_reg == $past(pdiv_reg)))
        else $error("invalid result changed stored setting");

    a_zero_m_bad: assert property (@(posedge mclk) disable iff (!rst_n)
        (req_valid && !busy_reg && req.m == '0) |-> ##18 (done_reg && inv_reg))
        else $error("zero divide value not flagged");

    a_shift_log: assert property (@(posedge mclk) disable iff (!rst_n)
        (done_reg && !inv_reg && cfg_reg.p != '0) |->
        (({23'h0, req_reg.m} << (4 - cfg_reg.p)) <= {20'h0, cfg_reg.n})
        && ({20'h0, cfg_reg.n} < ({23'h0, req_reg.m} << (5 - cfg_reg.p))))
        else $error("shift value does not match log2 of n over m");

    a_div_identity: assert property (@(posedge mclk) disable iff (!rst_n)
        (done_reg && !inv_reg) |->
        ((({20'h0, cfg_reg.n} << cfg_reg.p) ==
          {23'h0, req_reg.m} * {26'h0, cfg_reg.q} + {23'h0, cfg_reg.r})
         && ({23'h0, cfg_reg.r} < {23'h0, req_reg.m})))
        else $error("scaled n is not m times q plus r");

    a_q_window: assert property (@(posedge mclk) disable iff (!rst_n)
        (done_reg && !inv_reg) |-> (cfg_reg.q >= 6'(Q_MIN)
                                    && cfg_reg.p <= 3'(P_MAX)))
        else $error("accepted setting outside q or p range");

    a_vco_band: assert property (@(posedge mclk) disable iff (!rst_n)
        (done_reg && !inv_reg) |->
        (REF_U * {20'h0, cfg_reg.n} >= 32'(VCO_MIN_KHZ) * {23'h0, req_reg.m})
        && (REF_U * {20'h0, cfg_reg.n} <= 32'(VCO_MAX_KHZ) * {23'h0, req_reg.m}))
        else $error("accepted setting outside oscillator band");

    a_standby_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        (done_reg && !inv_reg) |-> (stby_reg == (req_reg.pdiv == '0)
                                    && pdiv_reg == req_reg.pdiv))
        else $error("standby does not follow zero post-divider");

    a_busy_span: assert property (@(posedge mclk) disable iff (!rst_n)
        (req_valid && !busy_reg) |=> busy_reg[*8])
        else $error("busy dropped early during calculation");

endmodule // pdc_calc

// ===== verif/pdc_master.sv
// configuration master model that presents divider ratio requests
`timescale 1ns/1ps
module pdc_master
    import pdc_pkg::*;
(
    input  wire logic mclk,
    input  wire logic busy,
    output logic      req_valid,
    output pdc_req_t  req
);
    // idle until the bench asks for a transfer
    initial begin
        req_valid = 1'b0;
        req       = '0;
    end

    // hold the request until an edge sees busy low; call just after an edge
    task automatic send(input pdc_req_t r, output bit ok);
        int i;
        ok        = 1'b0;
        req_valid = 1'b1;
        req       = r;
        for (i = 0; i < 40 && !ok; i++) begin
            ok = (busy === 1'b0);
            @(posedge mclk);
            #1;
        end
        req_valid = 1'b0;
        req       = ~r; // released lines keep no stale value
    endtask

    // one-cycle request regardless of busy, used only to provoke a refusal
    task automatic poke(input pdc_req_t r);
        req_valid = 1'b1;
        req       = r;
        @(posedge mclk);
        #1;
        req_valid = 1'b0;
        req       = ~r;
    endtask
endmodule // pdc_master

// ===== verif/pll_divider_setting_calc_tb_top.sv
// self-checking bench for the divider setting calculator
`timescale 1ns/1ps
module pll_divider_setting_calc_tb_top;
    import pdc_pkg::*;
    localparam int REF = 27000;
    logic              mclk;
    logic              rst_n;
    logic              req_valid;
    logic              busy;
    logic              done;
    logic              invalid;
    logic              standby;
    logic [PDIV_W-1:0] pdiv;
    logic [PDIV_W-1:0] exp_pdiv;
    pdc_req_t          req;
    pdc_cfg_t          cfg;
    pdc_cfg_t          exp_cfg;
    int                failures;
    int                checked;

    pdc_calc #(.REF_KHZ(REF)) i_dut (.mclk(mclk), .rst_n(rst_n),
        .req_valid(req_valid), .req(req), .busy(busy), .done(done),
        .invalid(invalid), .cfg(cfg), .pdiv(pdiv), .standby(standby));
    pdc_master i_master (.mclk(mclk), .busy(busy), .req_valid(req_valid),
        .req(req));

    // 125 MHz clock
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // reference model with exact integer math, no shared code
    function automatic pdc_cfg_t calc(input pdc_req_t r, output bit ok);
        longint n, m, ns, q, rr, p, k;
        n = r.n;
        m = r.m;
        k = 0;
        while (m != 0 && (m << (k + 1)) <= n) k++;
        p = (k >= 4) ? 0 : 4 - k;
        ns = n << p;
        q = (m != 0) ? ns / m : 0;
        rr = ns - m * q;
        ok = n >= 1 && m >= 1 && n >= m && n * REF >= 80000 * m &&
             n * REF <= 200000 * m && q >= 16 && q <= 63 && rr <= 511;
        calc = '{n: r.n, r: rr[8:0], q: q[5:0], p: p[2:0]};
    endfunction

    // wait for done from cycle c and judge the result of request r
    task automatic finish(input pdc_req_t r, input int c);
        bit       v;
        pdc_cfg_t e;
        e = calc(r, v);
        while (done !== 1'b1 && c < 40) begin
            @(posedge mclk);
            #1;
            c++;
        end
        chk("latency", c, LAT_CYC);
        if (c >= 40) test_done();
        if (v) begin
            exp_cfg  = e;
            exp_pdiv = r.pdiv;
        end
        chk("invalid", invalid, !v);
        chk("cfg", cfg, exp_cfg);
        chk("pdiv", pdiv, exp_pdiv);
        chk("standby", standby, exp_pdiv == 0);
        chk("busy end", busy, 0);
    endtask

    task automatic issue(input pdc_req_t r);
        bit ok;
        i_master.send(r, ok);
        chk("taken", ok, 1);
        chk("busy", busy, 1);
    endtask

    // table of ratios, back to back: edges of the band, fractions, refusals
    task automatic t_table();
        pdc_req_t t[11];
        t = '{'{4, 1, 2}, '{11, 2, 2}, '{100, 31, 127}, '{80, 27, 1},
              '{200, 27, 0}, '{79, 27, 5}, '{1, 2, 3}, '{0, 1, 1},
              '{12, 0, 1}, '{201, 27, 4}, '{4095, 511, 1}};
        foreach (t[i]) begin
            issue(t[i]);
            finish(t[i], 1);
        end
    endtask

    // a request made while busy is dropped and yields no second result
    task automatic t_ignore();
        pdc_req_t a;
        int       extra;
        a = '{11, 2, 2};
        extra = 0;
        issue(a);
        repeat (3) @(posedge mclk);
        #1;
        i_master.poke('{8, 1, 1});
        finish(a, 5);
        repeat (20) begin
            @(posedge mclk);
            #1;
            if (done === 1'b1) extra++;
        end
        chk("extra done", extra, 0);
    endtask

    // reset, then the scenarios in turn
    initial begin
        failures = 0;
        checked  = 0;
        exp_cfg  = '0;
        exp_pdiv = '0;
        rst_n    = 1'b0;
        repeat (8) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        chk("rst busy", busy, 0);
        chk("rst done", done, 0);
        chk("rst invalid", invalid, 0);
        chk("rst cfg", cfg, 0);
        chk("rst pdiv", pdiv, 0);
        chk("rst standby", standby, 1);
        t_table();
        t_ignore();
        test_done();
    end
endmodule // pll_divider_setting_calc_tb_top
